// ==== hdl/dual_temp_monitor_core.sv ====
// Behaviour
// R01: Load temperatures only when conversion completes
// R02: Start conversions periodically at programmed rate
// R03: One-shot command starts conversion at once
// R04: Local temperature reported in one-degree steps
// R05: Remote: eighth-degree extended, one-degree basic
// R06: Slow rates select extended remote mode
// R07: Fast rates select basic remote mode
// R08: Alarm above high or below low limit
// R09: Two three-level pins pick nine addresses
// R10: Standby from register bit or pin
// R11: Standby pin high runs, low sleeps
// R12: Alert is open drain, pulled low
// R13: Sample address pins at reset, each conversion (code skips resampling at the fastest rate)
// R14: Temperatures read zero until first result
// R15: Standby stops periodic starts, registers stay live
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
`include "dtm_cfg.svh"
module dual_temp_monitor_core #(
    parameter int unsigned SLOWEST_PERIOD_CYC =
        `SLOWEST_PERIOD_MS * `CLK_KHZ,
    parameter logic [6:0]  BASE_ADDR          = 7'h20
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    input  wire dtm_pkg::meas_t     meas,
    input  wire logic               conv_done,
    output logic                    conv_start,
    output logic                    conv_extended,
    input  wire logic               low_power_request_n,
    input  wire dtm_pkg::addr_pins_t addr_pins,
    output logic [6:0]              bus_address,
    output logic                    standby_active,
    output logic                    alert_o,
    output logic                    alert_oe,
    output logic                    irq
);
    import dtm_pkg::*;
    function automatic logic [1:0] pin_level(input logic [1:0] p);
        pin_level = (p == `PIN_HIGH)  ? 2'h2 :
                    (p == `PIN_FLOAT) ? 2'h1 : 2'h0;
    endfunction : pin_level

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic       low_power_request_n_s1_r, low_power_request_n_s2_r;
    addr_pins_t pins_s1_r, pins_s2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_power_request_n_s1_r <= 1'b1;
            low_power_request_n_s2_r <= 1'b1;
            pins_s1_r <= '0;
            pins_s2_r <= '0;
        end else begin
            low_power_request_n_s1_r <= low_power_request_n;
            low_power_request_n_s2_r <= low_power_request_n_s1_r;
            pins_s1_r <= addr_pins;
            pins_s2_r <= pins_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic               standby_sw_r;
    logic [2:0]         rate_r;
    logic [7:0]         high_r, low_r;
    logic [7:0]         local_temp_r;
    logic [10:0]        remote_temp_r;
    logic [`IRQ_W-1:0]  irq_stat_r, irq_en_r;
    logic [3:0]         addr_idx_r;
    logic               init_r;
    logic               ext_cur_r;

    // AXI state
    logic               aw_have_r, w_have_r;
    logic [7:0]         aw_addr_r;
    logic [31:0]        w_data_r;
    logic [3:0]         w_strb_r;

    logic               sched_start_w, busy_w;
    logic               wr_go_w, wr_ok_w, lane0_w;
    logic               oneshot_w;
    logic               cap_w, samp_w;
    logic               standby_w;
    logic [`IRQ_W-1:0]  irq_set_w, irq_clr_w;
    logic [3:0]         addr_idx_w;
    logic [7:0]         remote_int_w;
    logic [31:0]        rd_data_w;
    logic               rd_ok_w;

    assign wr_go_w   = aw_have_r && w_have_r && !bvalid;
    assign lane0_w   = w_strb_r[0];
    assign wr_ok_w   = (aw_addr_r == `OFS_CTRL)
                    || (aw_addr_r == `OFS_RATE)
                    || (aw_addr_r == `OFS_HIGH_LIMIT)
                    || (aw_addr_r == `OFS_LOW_LIMIT)
                    || (aw_addr_r == `OFS_IRQ_CLEAR)
                    || (aw_addr_r == `OFS_IRQ_ENABLE);
    assign oneshot_w = wr_go_w && lane0_w && aw_addr_r == `OFS_CTRL
                    && w_data_r[`CTRL_ONESHOT]; // [R03]
    assign irq_clr_w = (wr_go_w && lane0_w
                    && aw_addr_r == `OFS_IRQ_CLEAR)
                    ? w_data_r[`IRQ_W-1:0] : '0;
    // Pin is active low; either source forces standby
    assign standby_w = standby_sw_r || !low_power_request_n_s2_r; // [R10] [R11]
    assign cap_w     = conv_done && busy_w; // [R01]
    assign remote_int_w = meas.remote_raw[10:3];
    // Alarm compares the fresh result against signed limits
    assign irq_set_w[`IRQ_LOCAL_HIGH]  = cap_w &&
        $signed(meas.local_raw) > $signed(high_r); // [R08]
    assign irq_set_w[`IRQ_LOCAL_LOW]   = cap_w &&
        $signed(meas.local_raw) < $signed(low_r); // [R08]
    assign irq_set_w[`IRQ_REMOTE_HIGH] = cap_w &&
        $signed(remote_int_w) > $signed(high_r); // [R08]
    assign irq_set_w[`IRQ_REMOTE_LOW]  = cap_w &&
        $signed(remote_int_w) < $signed(low_r); // [R08]
    assign irq_set_w[`IRQ_CONV_DONE]   = cap_w;
    assign addr_idx_w = 4'(pin_level(pins_s2_r.pin_a)) * 4'h3
                      + 4'(pin_level(pins_s2_r.pin_b)); // [R09]
    // Fastest rate skips resampling to save pin bias time
    assign samp_w = init_r
                 || (sched_start_w && rate_r != `RATE_FASTEST); // [R13]

    ////////////////////////////////////////////////////////////////////////
    // Read decode
    always_comb begin
        rd_ok_w   = 1'b1;
        rd_data_w = 32'h0000_0000;
        if (araddr == `OFS_CTRL) begin
            rd_data_w[`CTRL_STANDBY] = standby_sw_r;
        end else if (araddr == `OFS_RATE) begin
            rd_data_w[2:0] = rate_r;
        end else if (araddr == `OFS_HIGH_LIMIT) begin
            rd_data_w[7:0] = high_r;
        end else if (araddr == `OFS_LOW_LIMIT) begin
            rd_data_w[7:0] = low_r;
        end else if (araddr == `OFS_LOCAL_TEMP) begin
            rd_data_w[7:0] = local_temp_r;
        end else if (araddr == `OFS_REMOTE_TEMP) begin
            rd_data_w[10:0] = remote_temp_r;
        end else if (araddr == `OFS_STATUS) begin
            rd_data_w[7:0] = {addr_idx_r, ext_cur_r, conv_extended,
                              standby_w, busy_w};
        end else if (araddr == `OFS_IRQ_STATUS) begin
            rd_data_w[`IRQ_W-1:0] = irq_stat_r;
        end else if (araddr == `OFS_IRQ_ENABLE) begin
            rd_data_w[`IRQ_W-1:0] = irq_en_r;
        end else if (araddr == `OFS_IRQ_CLEAR) begin
            rd_data_w = 32'h0000_0000;
        end else begin
            rd_ok_w = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awready   <= 1'b0;
                aw_have_r <= 1'b1;
                aw_addr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wready   <= 1'b0;
                w_have_r <= 1'b1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end
            if (wr_go_w) begin
                bvalid    <= 1'b1;
                bresp     <= wr_ok_w ? `RESP_OKAY : `RESP_SLVERR;
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data_w;
            rresp   <= rd_ok_w ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers; stay writable in standby [R15]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_sw_r <= 1'b0;
            rate_r       <= `RATE_RST;
            high_r       <= `HIGH_LIMIT_RST;
            low_r        <= `LOW_LIMIT_RST;
            irq_en_r     <= '0;
        end else if (wr_go_w && lane0_w) begin
            if (aw_addr_r == `OFS_CTRL) begin
                standby_sw_r <= w_data_r[`CTRL_STANDBY]; // [R10]
            end else if (aw_addr_r == `OFS_RATE) begin
                rate_r <= w_data_r[2:0];
            end else if (aw_addr_r == `OFS_HIGH_LIMIT) begin
                high_r <= w_data_r[7:0];
            end else if (aw_addr_r == `OFS_LOW_LIMIT) begin
                low_r <= w_data_r[7:0];
            end else if (aw_addr_r == `OFS_IRQ_ENABLE) begin
                irq_en_r <= w_data_r[`IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion control and results
    conv_sched #(
        .SLOWEST_PERIOD_CYC (SLOWEST_PERIOD_CYC)
    ) u_sched (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rate    (rate_r),
        .standby (standby_w),
        .oneshot (oneshot_w),
        .done    (conv_done),
        .start_o (sched_start_w),
        .busy_o  (busy_w)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_temp_r  <= `TEMP_RST; // [R14]
            remote_temp_r <= `REMOTE_RST; // [R14]
            conv_start    <= 1'b0;
            conv_extended <= (`RATE_RST <= `RATE_EXT_MAX); // [R07]
            ext_cur_r     <= 1'b1;
        end else begin
            conv_start    <= sched_start_w;
            conv_extended <= rate_r <= `RATE_EXT_MAX; // [R06] [R07]
            if (sched_start_w) begin
                ext_cur_r <= conv_extended;
            end
            if (cap_w) begin
                local_temp_r <= meas.local_raw; // [R01] [R04]
                // Basic mode drops the fraction bits
                remote_temp_r <= ext_cur_r ? meas.remote_raw
                    : {meas.remote_raw[10:3], 3'h0}; // [R01] [R05]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address selection, standby, interrupts
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_r      <= 1'b1;
            addr_idx_r  <= 4'h0;
            bus_address <= 7'h00;
        end else begin
            init_r <= 1'b0;
            if (samp_w) begin
                addr_idx_r  <= addr_idx_w; // [R13]
                bus_address <= BASE_ADDR + 7'(addr_idx_w); // [R09]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r     <= '0;
            irq            <= 1'b0;
            alert_o        <= 1'b0;
            alert_oe       <= 1'b0;
            standby_active <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            irq_stat_r     <= (irq_stat_r & ~irq_clr_w) | irq_set_w;
            irq            <= |(irq_stat_r & irq_en_r);
            alert_o        <= 1'b0;
            alert_oe       <= |(irq_stat_r & irq_en_r); // [R12]
            standby_active <= standby_w; // [R10]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    result_hold_a: assert property ( // [R01]
        @(posedge aclk) disable iff (!aresetn)
        !cap_w |=> $stable(local_temp_r) && $stable(remote_temp_r)
    ) else $error("temperature changed without a conversion");

    local_load_a: assert property ( // [R04]
        @(posedge aclk) disable iff (!aresetn)
        cap_w |=> local_temp_r == $past(meas.local_raw)
    ) else $error("local result not loaded");

    remote_basic_a: assert property ( // [R05]
        @(posedge aclk) disable iff (!aresetn)
        cap_w && !ext_cur_r |=> remote_temp_r[2:0] == 3'h0
    ) else $error("basic mode kept fraction bits");

    ext_mode_a: assert property ( // [R06]
        @(posedge aclk) disable iff (!aresetn)
        ##1 conv_extended == ($past(rate_r) <= `RATE_EXT_MAX)
    ) else $error("extended mode does not follow rate");

    fast_basic_a: assert property ( // [R07]
        @(posedge aclk) disable iff (!aresetn)
        rate_r > `RATE_EXT_MAX ##1 $stable(rate_r) |-> !conv_extended
    ) else $error("fast rate not in basic mode");

    alarm_high_a: assert property ( // [R08]
        @(posedge aclk) disable iff (!aresetn)
        cap_w && $signed(meas.local_raw) > $signed(high_r)
        |=> irq_stat_r[`IRQ_LOCAL_HIGH]
    ) else $error("high alarm not flagged");

    addr_range_a: assert property ( // [R09]
        @(posedge aclk) disable iff (!aresetn) !init_r |->
        addr_idx_r <= 4'h8 && bus_address == BASE_ADDR + 7'(addr_idx_r)
    ) else $error("address out of nine slots");

    addr_sample_a: assert property ( // [R13]
        @(posedge aclk) disable iff (!aresetn)
        sched_start_w && rate_r == `RATE_FASTEST && !init_r
        |=> $stable(addr_idx_r)
    ) else $error("address resampled at fastest rate");

    standby_pin_a: assert property ( // [R11]
        @(posedge aclk) disable iff (!aresetn)
        !low_power_request_n_s2_r |=> standby_active
    ) else $error("low standby pin did not enter standby");

    alert_drive_a: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        ##1 alert_oe == $past(|(irq_stat_r & irq_en_r)) && !alert_o
    ) else $error("alert not pulled low for enabled event");
endmodule : dual_temp_monitor_core
`default_nettype wire

// ==== hdl/dtm_cfg.svh ====
`ifndef DTM_CFG_SVH
`define DTM_CFG_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_RATE        8'h04
`define OFS_HIGH_LIMIT  8'h08
`define OFS_LOW_LIMIT   8'h0C
`define OFS_LOCAL_TEMP  8'h10
`define OFS_REMOTE_TEMP 8'h14
`define OFS_STATUS      8'h18
`define OFS_IRQ_STATUS  8'h1C
`define OFS_IRQ_CLEAR   8'h20
`define OFS_IRQ_ENABLE  8'h24

// Control fields
`define CTRL_STANDBY    0
`define CTRL_ONESHOT    1

// Reset values
`define RATE_RST        3'h4
`define HIGH_LIMIT_RST  8'h46
`define LOW_LIMIT_RST   8'h00
`define TEMP_RST        8'h00
`define REMOTE_RST      11'h000

// Rate codes: 0 is 1/16 Hz, each step doubles, 7 is 8 Hz
`define RATE_EXT_MAX    3'h3
`define RATE_FASTEST    3'h7

// Interrupt bits
`define IRQ_W           5
`define IRQ_LOCAL_HIGH  0
`define IRQ_LOCAL_LOW   1
`define IRQ_REMOTE_HIGH 2
`define IRQ_REMOTE_LOW  3
`define IRQ_CONV_DONE   4

// Three-level address pin codes
`define PIN_LOW         2'h0
`define PIN_HIGH        2'h1
`define PIN_FLOAT       2'h2

// Timing
`define CLK_KHZ           50000
`define SLOWEST_PERIOD_MS 16000

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== hdl/dtm_pkg.sv ====
`default_nettype none
package dtm_pkg;
    `include "dtm_cfg.svh"

    typedef struct packed {
        logic [7:0]  local_raw;
        logic [10:0] remote_raw;
    } meas_t;

    typedef struct packed {
        logic [1:0] pin_a;
        logic [1:0] pin_b;
    } addr_pins_t;

    typedef enum logic {
        SCHED_IDLE,
        SCHED_BUSY
    } sched_state_t;
endpackage : dtm_pkg
`default_nettype wire

// ==== hdl/conv_sched.sv ====
`default_nettype none
module conv_sched #(
    parameter int unsigned SLOWEST_PERIOD_CYC = 32'd800_000_000
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] rate,
    input  wire logic       standby,
    input  wire logic       oneshot,
    input  wire logic       done,
    output logic            start_o,
    output logic            busy_o
);
    import dtm_pkg::*;

    logic [31:0]  cnt_r;
    logic         pend_r;
    sched_state_t state_r;
    logic [31:0]  period_w;
    logic         tick_w;
    logic         go_w;

    assign period_w = SLOWEST_PERIOD_CYC >> rate;
    assign tick_w   = (cnt_r + 32'h0000_0001) >= period_w;
    // Periodic slots are suppressed in standby [R15]
    assign go_w     = (tick_w && !standby) || oneshot || pend_r; // [R02] [R03]

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r   <= 32'h0000_0000;
            pend_r  <= 1'b0;
            start_o <= 1'b0;
            state_r <= SCHED_IDLE;
        end else begin
            start_o <= 1'b0;
            if (start_o) begin
                cnt_r <= 32'h0000_0000;
            end else if (!tick_w) begin
                cnt_r <= cnt_r + 32'h0000_0001;
            end
            // One-shot during a conversion waits for it to finish
            if (start_o) begin
                pend_r <= 1'b0;
            end else if (oneshot) begin
                pend_r <= 1'b1; // [R03]
            end
            case (state_r)
                SCHED_IDLE: begin
                    if (start_o) begin
                        state_r <= SCHED_BUSY;
                    end else if (go_w) begin
                        start_o <= 1'b1; // [R02] [R03]
                    end
                end
                SCHED_BUSY: begin
                    if (done) begin
                        state_r <= SCHED_IDLE;
                    end
                end
                default: state_r <= SCHED_IDLE;
            endcase
        end
    end

    assign busy_o = (state_r == SCHED_BUSY);

    ////////////////////////////////////////////////////////////////////////
    oneshot_start_a: assert property ( // [R03]
        @(posedge aclk) disable iff (!aresetn)
        oneshot && state_r == SCHED_IDLE && !start_o |=> start_o
    ) else $error("one-shot did not start a conversion");

    no_periodic_a: assert property ( // [R15]
        @(posedge aclk) disable iff (!aresetn)
        standby && !oneshot && !pend_r |=> !start_o
    ) else $error("periodic start while in standby");
endmodule : conv_sched
`default_nettype wire

// ==== sim/adc_model.sv ====
`default_nettype none
module adc_model
    import dtm_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       conv_start,
    input  wire logic [7:0] lat,
    input  wire meas_t      meas_in,
    output logic            conv_done,
    output meas_t           meas
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // Latency loaded from lat at each start, so answers come prompt or slow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 8'h00;
        end else if (conv_start) begin
            cnt_r <= lat;
        end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    assign conv_done = (cnt_r == 8'h01);
    // Inverted outside the valid cycle, so a stale sample shows
    assign meas      = conv_done ? meas_in : ~meas_in;
endmodule : adc_model
`default_nettype wire

// ==== sim/testbench.sv ====
`default_nettype none
`include "dtm_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dtm_pkg::*;

    localparam logic [6:0] BASE = 7'h20;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lat = 8'h0A;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, low_power_request_n = 1'b1;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'hF;
    meas_t       meas_in = '0, meas;
    addr_pins_t  addr_pins = '0;
    logic        awready, wready, bvalid, arready, rvalid, conv_done;
    logic        conv_start, conv_extended, standby_active;
    logic        alert_o, alert_oe, irq;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [6:0]  bus_address;
    int          n_fail = 0, cmp_count = 0, c;
    // Pull-up on the open-drain alert line
    wire         alert_pin = alert_oe ? alert_o : 1'b1;

    always #10 aclk = ~aclk;

    dual_temp_monitor_core #(.SLOWEST_PERIOD_CYC(1024), .BASE_ADDR(BASE)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .meas(meas), .conv_done(conv_done), .conv_start(conv_start),
        .conv_extended(conv_extended),
        .low_power_request_n(low_power_request_n), .addr_pins(addr_pins),
        .bus_address(bus_address), .standby_active(standby_active),
        .alert_o(alert_o), .alert_oe(alert_oe), .irq(irq));

    adc_model adc (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
        .lat(lat), .meas_in(meas_in), .conv_done(conv_done), .meas(meas));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bound(input int n);
        if (n >= 2000) begin
            n_fail++;
            wrap_up();
        end
    endtask : bound

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 2000);
        bound(n);
        rs = bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 2000);
        bound(n);
        v = rdata;
        rs = rresp;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(d, exp);
    endtask : rd_chk

    // Edges until start (sel 0) or done (sel 1) is sampled high
    task automatic wait_ev(input bit sel, output int n);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (((sel ? conv_done : conv_start) !== 1'b1) && n < 2000);
        bound(n);
    endtask : wait_ev

    task automatic oneshot_conv();
        wr(`OFS_CTRL, 32'h0000_0002, r);
        wait_ev(1'b1, c);
        repeat (3) @(posedge aclk);
    endtask : oneshot_conv

    function automatic int lvl(input int p);
        return (p == 0) ? 0 : (p == 2) ? 1 : 2;
    endfunction : lvl

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(`OFS_LOCAL_TEMP, 8'h00);
        rd_chk(`OFS_REMOTE_TEMP, 8'h00);
        rd_chk(`OFS_HIGH_LIMIT, 8'h46);
        rd_chk(`OFS_RATE, 8'h04);
        rd(8'h28, d, r);
        chk(r, `RESP_SLVERR);
        chk(d, 32'h0000_0000);
        wr(`OFS_LOCAL_TEMP, 32'h0000_0055, r);
        chk(r, `RESP_SLVERR);
        $display("test reset and refusal done");
        for (int k = 0; k < 8; k++) begin
            wr(`OFS_RATE, k, r);
            repeat (3) @(posedge aclk);
            chk(conv_extended, k <= 3);
        end
        wr(`OFS_RATE, 32'h0000_0003, r);
        wait_ev(1'b0, c);
        wait_ev(1'b0, c);
        wait_ev(1'b0, c);
        chk(c >= 120 && c <= 150, 1'b1);
        // Let the running conversion end so the one-shot finds idle
        wait_ev(1'b1, c);
        $display("test rate done");
        wr(`OFS_RATE, 32'h0000_0000, r);
        lat <= 8'd200;
        meas_in <= '{local_raw: 8'h19, remote_raw: 11'h0CB};
        oneshot_conv();
        rd_chk(`OFS_LOCAL_TEMP, 8'h19);
        rd_chk(`OFS_REMOTE_TEMP, 11'h0CB);
        meas_in <= '{local_raw: 8'h20, remote_raw: 11'h100};
        repeat (4) @(posedge aclk);
        rd_chk(`OFS_LOCAL_TEMP, 8'h19);
        wr(`OFS_CTRL, 32'h0000_0002, r);
        wait_ev(1'b0, c);
        chk(c >= 1 && c <= 3, 1'b1);
        wait_ev(1'b1, c);
        repeat (3) @(posedge aclk);
        rd_chk(`OFS_LOCAL_TEMP, 8'h20);
        wr(`OFS_RATE, 32'h0000_0007, r);
        lat <= 8'd1;
        meas_in <= '{local_raw: 8'h19, remote_raw: 11'h0CB};
        oneshot_conv();
        oneshot_conv();
        rd_chk(`OFS_REMOTE_TEMP, 11'h0C8);
        rd_chk(`OFS_LOCAL_TEMP, 8'h19);
        $display("test conversion done");
        wr(`OFS_RATE, 32'h0000_0000, r);
        wr(`OFS_IRQ_ENABLE, 32'h0000_001F, r);
        meas_in <= '{local_raw: 8'h50, remote_raw: 11'h0C8};
        wr(`OFS_IRQ_CLEAR, 32'h0000_001F, r);
        oneshot_conv();
        rd_chk(`OFS_IRQ_STATUS, 8'h11);
        chk(irq, 1'b1);
        chk(alert_pin, 1'b0);
        meas_in <= '{local_raw: 8'h19, remote_raw: 11'h7F8};
        wr(`OFS_IRQ_CLEAR, 32'h0000_001F, r);
        oneshot_conv();
        rd_chk(`OFS_IRQ_STATUS, 8'h18);
        wr(`OFS_IRQ_ENABLE, 32'h0000_0000, r);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        chk(alert_pin, 1'b1);
        $display("test alarm done");
        for (int pa = 0; pa < 3; pa++) begin
            for (int pb = 0; pb < 3; pb++) begin
                addr_pins <= '{pin_a: 2'(pa), pin_b: 2'(pb)};
                repeat (4) @(posedge aclk);
                oneshot_conv();
                chk(bus_address, BASE + 3 * lvl(pa) + lvl(pb));
            end
        end
        wr(`OFS_RATE, 32'h0000_0007, r);
        addr_pins <= '{pin_a: 2'h0, pin_b: 2'h0};
        repeat (4) @(posedge aclk);
        oneshot_conv();
        chk(bus_address, BASE + 7'h04);
        $display("test address done");
        low_power_request_n <= 1'b0;
        repeat (30) @(posedge aclk);
        chk(standby_active, 1'b1);
        c = 0;
        repeat (64) begin
            @(posedge aclk);
            if (conv_start === 1'b1) c++;
        end
        chk(c, 0);
        wr(`OFS_HIGH_LIMIT, 32'h0000_003C, r);
        rd_chk(`OFS_HIGH_LIMIT, 8'h3C);
        low_power_request_n <= 1'b1;
        wait_ev(1'b0, c);
        chk(c <= 20, 1'b1);
        chk(standby_active, 1'b0);
        wr(`OFS_CTRL, 32'h0000_0001, r);
        repeat (3) @(posedge aclk);
        chk(standby_active, 1'b1);
        rd_chk(`OFS_CTRL, 8'h01);
        wr(`OFS_CTRL, 32'h0000_0000, r);
        $display("test standby done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
